// ### design/start_stop_regs.vh
`ifndef START_STOP_REGS_VH
`define START_STOP_REGS_VH
// Functional notes
// - Stop selection 0..100: coast after that many seconds once start drops.
// - Stop selection 1000..1100: coast after (setting - 1000) seconds.
// - Stop selection 9999 or 8888: ramp down to stop when start drops.
// - Settings 1000..1100 and 8888: forward input runs, reverse input selects direction.
// - Two-wire, 0..100 or 9999: forward alone runs forward, reverse alone runs reverse.
// - Two-wire, 0..100 or 9999: both on while running decelerates; both off stops as the stop selection sets.
// - 1000..1100/8888: fwd off stop, fwd only forward, both on reverse.
// - Stop-hold active enables three-wire self-hold; start inputs act as triggers.
// - Three-wire: start latches on input on-then-off; other input pulse reverses, except in 1000..1100/8888.
// - Three-wire: stop-hold going inactive clears the latch and decelerates.
// - Jog active with jog enabled makes stop-hold ignored.
// - Output shutoff stops output but keeps the self-hold latch.
// - Stop-hold on its own terminal; code 25 in any input selection routes it.
// - Open-collector selections reset to codes 0..4.
// - First relay selection resets to code 99, the fault output.
// - Second relay selection resets to 9999, no function.
// - Stop and output selections writable only while user group setting is zero.
// - Output codes 0..99 positive logic, 100..199 the same signal inverted.
// - Output shutoff input cuts the drive output at once, motor coasts.

// Register addresses on the plain port
`define SS_ADDR_STATUS 8'h00
`define SS_ADDR_USER_GROUP 8'hA0
`define SS_ADDR_IN_FIRST 8'hB2
`define SS_ADDR_OUT_FIRST 8'hBE
`define SS_ADDR_LAST 8'hC4
`define SS_ADDR_STOP_SEL 8'hFA

// Word indices inside the selection store
`define SS_IDX_IN_SECOND 5'h01
`define SS_IDX_OUT_FIRST 5'h0C
`define SS_IDX_RELAY1 5'h11
`define SS_NUM_IN_SEL 12
`define SS_NUM_SEL 19

// Setting values
`define SS_STOP_SEL_RESET 16'h270F
`define SS_STOP_DECEL_DIR 16'h22B8
`define SS_COAST_MAX 16'h0064
`define SS_COAST_OFS 16'h03E8
`define SS_COAST_OFS_MAX 16'h044C
`define SS_USER_GROUP_RESET 16'h0000

// Function codes
`define SS_FN_STOP_HOLD 16'h0019
`define SS_FN_FWD_START 16'h003C
`define SS_FN_REV_START 16'h003D
`define SS_FN_NONE 16'h270F
`define SS_FN_FAULT 16'h0063
`define SS_FN_INV_FIRST 16'h0064
`define SS_FN_INV_LAST 16'h00C7

// Status register fields
`define SS_STAT_STATE_MSB 2
`define SS_STAT_LATCH_RUN 3
`define SS_STAT_LATCH_REV 4
`define SS_STAT_THREE_WIRE 5
`define SS_STAT_STOP_HOLD 6

// Timing
`define SS_TICK_SEC 1
`define SS_CLK_HZ 25000000
`define SS_TICK_CYCLES (`SS_TICK_SEC * `SS_CLK_HZ)
`endif

// ### design/param_store.v
`timescale 1ns/100ps
`include "start_stop_regs.vh"
module param_store #(
    parameter WORDS = `SS_NUM_SEL,
    parameter WIDTH = 16
) (
    input wire clk,
    input wire rst,
    input wire wrEn,
    input wire [4:0] wrIdx,
    input wire [WIDTH-1:0] wrData,
    input wire rdEn,
    input wire [4:0] rdIdx,
    output reg [WIDTH-1:0] rdData_ff,
    output wire [WORDS*WIDTH-1:0] allWords
);
    reg [WIDTH-1:0] mem_ff [0:WORDS-1];
    integer i;
    genvar g;

    function [WIDTH-1:0] resetWord;
        input integer idx;
        begin
            if (idx == 0)
                resetWord = `SS_FN_FWD_START;
            else if (idx == `SS_IDX_IN_SECOND)
                resetWord = `SS_FN_REV_START;
            else if (idx >= `SS_IDX_OUT_FIRST && idx < `SS_IDX_RELAY1)
                resetWord = idx[WIDTH-1:0] - {11'h000, `SS_IDX_OUT_FIRST};
            else if (idx == `SS_IDX_RELAY1)
                resetWord = `SS_FN_FAULT;
            else
                resetWord = `SS_FN_NONE;
        end
    endfunction

    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < WORDS; i = i + 1)
                mem_ff[i] <= resetWord(i);
            rdData_ff <= {WIDTH{1'b0}};
        end else begin
            if (wrEn && wrIdx < WORDS)
                mem_ff[wrIdx] <= wrData;
            if (rdEn)
                rdData_ff <= (rdIdx < WORDS) ? mem_ff[rdIdx] : {WIDTH{1'b0}};
        end
    end

    generate
        for (g = 0; g < WORDS; g = g + 1) begin : flat
            assign allWords[g*WIDTH +: WIDTH] = mem_ff[g];
        end
    endgenerate
endmodule

// ### design/coast_delay_timer.v
`timescale 1ns/100ps
module coast_delay_timer #(
    parameter TICK_CYCLES = 25000000
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [6:0] delaySec,
    output wire expired
);
    reg [31:0] prescale_ff;
    reg [6:0] seconds_ff;
    wire tick;

    assign tick = (prescale_ff == TICK_CYCLES - 1);
    assign expired = run && (seconds_ff >= delaySec);

    // Held clear outside the wait so every new wait starts from zero
    always @(posedge clk) begin
        if (rst || !run) begin
            prescale_ff <= 32'h0000_0000;
            seconds_ff <= 7'h00;
        end else begin
            prescale_ff <= tick ? 32'h0000_0000 : prescale_ff + 32'h0000_0001;
            if (tick && seconds_ff != 7'h7F)
                seconds_ff <= seconds_ff + 7'h01;
        end
    end
endmodule

// ### design/start_stop_command_logic.v
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "start_stop_regs.vh"
module start_stop_command_logic #(
    parameter TICK_CYCLES = `SS_TICK_CYCLES,
    parameter WIDTH = 16
) (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [WIDTH-1:0] wrData,
    input wire wrEn,
    input wire rdEn,
    output wire [WIDTH-1:0] rdData,
    input wire fwdStartIn,
    input wire revStartIn,
    input wire [9:0] termIn,
    input wire stopHoldIn,
    input wire jogIn,
    input wire jogEnableIn,
    input wire outputShutoffIn,
    input wire rampDoneIn,
    input wire freqReachedFlag,
    input wire powerFailFlag,
    input wire overloadFlag,
    input wire freqDetectFlag,
    input wire faultFlag,
    output reg runFwdOut_ff,
    output reg runRevOut_ff,
    output reg decelReqOut_ff,
    output wire shutoffReqOut,
    output reg [4:0] openCollOut_ff,
    output reg [1:0] relayOut_ff
);
    localparam ST_STOP = 3'd0;
    localparam ST_FWD = 3'd1;
    localparam ST_REV = 3'd2;
    localparam ST_DECEL = 3'd3;
    localparam ST_WAIT = 3'd4;
    localparam ST_COAST = 3'd5;
    localparam NSEL = `SS_NUM_SEL;
    localparam NIN = `SS_NUM_IN_SEL;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [WIDTH-1:0] stopSel_ff;
    reg [WIDTH-1:0] userGroup_ff;
    reg [WIDTH-1:0] localRd_ff;
    reg rdFromStore_ff;
    reg fwdPrev_ff;
    reg revPrev_ff;
    reg latchRun_ff;
    reg latchRev_ff;
    reg nxt_latchRun;
    reg nxt_latchRev;
    reg stopHold;
    reg cmdRun;
    reg cmdRev;
    reg cmdBoth;
    reg [NIN-1:0] termVec;
    integer k;

    wire [NSEL*WIDTH-1:0] allSel;
    wire [WIDTH-1:0] storeRd;
    wire storeHit;
    wire storeWrOk;
    wire [4:0] storeIdx;
    wire [7:0] storeOfs;
    wire unlocked;
    wire coastMode;
    wire startDirMode;
    wire fwdFn;
    wire revFn;
    wire jogOverride;
    wire threeWire;
    wire fwdFall;
    wire revFall;
    wire timerRun;
    wire timerDone;
    wire [6:0] delaySec;
    wire running;
    wire [5:0] flags;

    // Setting decode shared by mode and delay logic
    function isCoastSel;
        input [WIDTH-1:0] sel;
        begin
            isCoastSel = (sel <= `SS_COAST_MAX) ||
                (sel >= `SS_COAST_OFS && sel <= `SS_COAST_OFS_MAX);
        end
    endfunction

    function isStartDirSel;
        input [WIDTH-1:0] sel;
        begin
            isStartDirSel = (sel == `SS_STOP_DECEL_DIR) ||
                (sel >= `SS_COAST_OFS && sel <= `SS_COAST_OFS_MAX);
        end
    endfunction

    function [6:0] coastDelay;
        input [WIDTH-1:0] sel;
        reg [WIDTH-1:0] d;
        begin
            d = (sel >= `SS_COAST_OFS) ? sel - `SS_COAST_OFS : sel;
            coastDelay = d[6:0];
        end
    endfunction

    function [WIDTH-1:0] selWord;
        input [NSEL*WIDTH-1:0] words;
        input integer idx;
        begin
            selWord = words[idx*WIDTH +: WIDTH];
        end
    endfunction

    // Output function: flags = {fault, freqDetect, overload, powerFail, freqReached, run}
    function termSignal;
        input [WIDTH-1:0] code;
        input [5:0] f;
        reg inv;
        reg [WIDTH-1:0] base;
        reg s;
        begin
            inv = (code >= `SS_FN_INV_FIRST) && (code <= `SS_FN_INV_LAST);
            base = inv ? code - `SS_FN_INV_FIRST : code;
            case (base)
                16'h0000: s = f[0];
                16'h0001: s = f[1];
                16'h0002: s = f[2];
                16'h0003: s = f[3];
                16'h0004: s = f[4];
                `SS_FN_FAULT: s = f[5];
                default: s = 1'b0;
            endcase
            termSignal = s ^ inv;
        end
    endfunction

    // Register port
    assign unlocked = (userGroup_ff == `SS_USER_GROUP_RESET);
    assign storeHit = (addr >= `SS_ADDR_IN_FIRST) && (addr <= `SS_ADDR_LAST);
    assign storeOfs = addr - `SS_ADDR_IN_FIRST;
    assign storeIdx = storeOfs[4:0];
    assign storeWrOk = wrEn && storeHit && ((addr < `SS_ADDR_OUT_FIRST) || unlocked);

    param_store #(
        .WORDS(NSEL),
        .WIDTH(WIDTH)
    ) selStore (
        .clk(clk),
        .rst(rst),
        .wrEn(storeWrOk),
        .wrIdx(storeIdx),
        .wrData(wrData),
        .rdEn(rdEn && storeHit),
        .rdIdx(storeIdx),
        .rdData_ff(storeRd),
        .allWords(allSel)
    );

    always @(posedge clk) begin
        if (rst) begin
            stopSel_ff <= `SS_STOP_SEL_RESET;
            userGroup_ff <= `SS_USER_GROUP_RESET;
        end else if (wrEn) begin
            if (addr == `SS_ADDR_USER_GROUP)
                userGroup_ff <= wrData;
            if (addr == `SS_ADDR_STOP_SEL && unlocked)
                stopSel_ff <= wrData;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            localRd_ff <= {WIDTH{1'b0}};
            rdFromStore_ff <= 1'b0;
        end else if (rdEn) begin
            rdFromStore_ff <= storeHit;
            case (addr)
                `SS_ADDR_STATUS: begin
                    localRd_ff <= {WIDTH{1'b0}};
                    localRd_ff[`SS_STAT_STATE_MSB:0] <= state_ff;
                    localRd_ff[`SS_STAT_LATCH_RUN] <= latchRun_ff;
                    localRd_ff[`SS_STAT_LATCH_REV] <= latchRev_ff;
                    localRd_ff[`SS_STAT_THREE_WIRE] <= threeWire;
                    localRd_ff[`SS_STAT_STOP_HOLD] <= stopHold;
                end
                `SS_ADDR_USER_GROUP: localRd_ff <= userGroup_ff;
                `SS_ADDR_STOP_SEL: localRd_ff <= stopSel_ff;
                default: localRd_ff <= {WIDTH{1'b0}};
            endcase
        end
    end

    // Read data appears in the cycle after the strobe and holds until the next read strobe
    assign rdData = rdFromStore_ff ? storeRd : localRd_ff;

    // Input terminal routing
    assign fwdFn = fwdStartIn && (selWord(allSel, 0) == `SS_FN_FWD_START);
    assign revFn = revStartIn &&
        (selWord(allSel, `SS_IDX_IN_SECOND) == `SS_FN_REV_START);

    always @* begin
        termVec = {termIn, revStartIn, fwdStartIn};
        stopHold = stopHoldIn;
        for (k = 0; k < NIN; k = k + 1)
            if (termVec[k] && selWord(allSel, k) == `SS_FN_STOP_HOLD)
                stopHold = 1'b1;
    end

    assign coastMode = isCoastSel(stopSel_ff);
    assign startDirMode = isStartDirSel(stopSel_ff);
    assign jogOverride = jogIn && jogEnableIn;
    assign threeWire = stopHold && !jogOverride;
    assign fwdFall = fwdPrev_ff && !fwdFn;
    assign revFall = revPrev_ff && !revFn;

    // Self-hold latch; shutoff input deliberately has no path here
    always @* begin
        nxt_latchRun = latchRun_ff;
        nxt_latchRev = latchRev_ff;
        if (!stopHold && !jogOverride) begin
            nxt_latchRun = 1'b0;
            nxt_latchRev = 1'b0;
        end else if (threeWire) begin
            if (startDirMode) begin
                if (fwdFall) begin
                    nxt_latchRun = 1'b1;
                    nxt_latchRev = revFn;
                end
            end else if (fwdFall) begin
                nxt_latchRun = 1'b1;
                nxt_latchRev = 1'b0;
            end else if (revFall) begin
                nxt_latchRun = 1'b1;
                nxt_latchRev = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            fwdPrev_ff <= 1'b0;
            revPrev_ff <= 1'b0;
            latchRun_ff <= 1'b0;
            latchRev_ff <= 1'b0;
        end else begin
            fwdPrev_ff <= fwdFn;
            revPrev_ff <= revFn;
            latchRun_ff <= nxt_latchRun;
            latchRev_ff <= nxt_latchRev;
        end
    end

    // Run command decode
    always @* begin
        cmdRun = 1'b0;
        cmdRev = 1'b0;
        cmdBoth = 1'b0;
        if (threeWire) begin
            cmdRun = latchRun_ff;
            cmdRev = latchRev_ff;
        end else if (startDirMode) begin
            cmdRun = fwdFn;
            cmdRev = fwdFn && revFn;
        end else begin
            cmdRun = fwdFn ^ revFn;
            cmdRev = revFn && !fwdFn;
            cmdBoth = fwdFn && revFn;
        end
    end

    // Stop sequencing
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STOP: begin
                if (cmdRun)
                    nxt_state = cmdRev ? ST_REV : ST_FWD;
            end
            ST_FWD, ST_REV: begin
                if (cmdRun)
                    nxt_state = cmdRev ? ST_REV : ST_FWD;
                else if (coastMode && !cmdBoth)
                    nxt_state = ST_WAIT;
                else
                    nxt_state = ST_DECEL;
            end
            ST_DECEL: begin
                if (cmdRun)
                    nxt_state = cmdRev ? ST_REV : ST_FWD;
                else if (rampDoneIn)
                    nxt_state = ST_STOP;
            end
            ST_WAIT: begin
                if (cmdRun)
                    nxt_state = cmdRev ? ST_REV : ST_FWD;
                else if (timerDone)
                    nxt_state = ST_COAST;
            end
            ST_COAST: begin
                if (cmdRun)
                    nxt_state = cmdRev ? ST_REV : ST_FWD;
            end
            default: nxt_state = ST_STOP;
        endcase
    end

    assign timerRun = (state_ff == ST_WAIT);
    assign delaySec = coastDelay(stopSel_ff);

    coast_delay_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) coastTimer (
        .clk(clk),
        .rst(rst),
        .run(timerRun),
        .delaySec(delaySec),
        .expired(timerDone)
    );

    always @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_STOP;
            runFwdOut_ff <= 1'b0;
            runRevOut_ff <= 1'b0;
            decelReqOut_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            runFwdOut_ff <= (nxt_state == ST_FWD);
            runRevOut_ff <= (nxt_state == ST_REV);
            // Ramp keeps braking during the coast delay; shutoff follows expiry
            decelReqOut_ff <= (nxt_state == ST_DECEL) || (nxt_state == ST_WAIT);
        end
    end

    // Combinational so an external shutoff reaches the drive with no cycle lost
    assign shutoffReqOut = (state_ff == ST_COAST) || outputShutoffIn;

    // Output terminal functions
    assign running = !shutoffReqOut && (state_ff != ST_STOP) && (state_ff != ST_COAST);
    assign flags = {faultFlag, freqDetectFlag, overloadFlag, powerFailFlag,
        freqReachedFlag, running};

    always @(posedge clk) begin
        if (rst) begin
            openCollOut_ff <= 5'h00;
            relayOut_ff <= 2'h0;
        end else begin
            for (k = 0; k < 5; k = k + 1)
                openCollOut_ff[k] <= termSignal(selWord(allSel, k + `SS_IDX_OUT_FIRST), flags);
            relayOut_ff[0] <= termSignal(selWord(allSel, `SS_IDX_RELAY1), flags);
            relayOut_ff[1] <= termSignal(selWord(allSel, `SS_IDX_RELAY1 + 1), flags);
        end
    end
endmodule

// ### bench/contact_panel.sv
`timescale 1ns/100ps
module contact_panel #(
    parameter logic [7:0] FAST = 8'h03,
    parameter logic [7:0] SLOW = 8'h28
) (
    input logic clk,
    input logic wantFwd,
    input logic wantRev,
    input logic wantHold,
    input logic rampSlow,
    input logic runOut,
    input logic decelReq,
    output logic fwdStartIn,
    output logic revStartIn,
    output logic stopHoldIn,
    output logic rampDoneIn
);
    // Contacts are plain wires; the bench moves them after the edge
    logic [7:0] speedCnt_ff = 8'hFF;
    assign fwdStartIn = wantFwd;
    assign revStartIn = wantRev;
    assign stopHoldIn = wantHold;
    // Zero speed stays reported while stopped, as a real ramp would
    assign rampDoneIn = speedCnt_ff >= (rampSlow ? SLOW : FAST);
    always @(posedge clk) begin
        if (runOut) begin
            speedCnt_ff <= 8'h00;
        end else if (decelReq && speedCnt_ff != 8'hFF) begin
            speedCnt_ff <= speedCnt_ff + 8'h01;
        end
    end
endmodule

// ### bench/start_stop_command_logic_checker.sv
`timescale 1ns/100ps
module start_stop_checker (
    input logic clk,
    input logic rst,
    input logic fwdStartIn,
    input logic revStartIn,
    input logic [9:0] termIn,
    input logic stopHoldIn,
    input logic jogIn,
    input logic outputShutoffIn,
    input logic rampDoneIn,
    input logic runFwdOut_ff,
    input logic runRevOut_ff,
    input logic decelReqOut_ff,
    input logic shutoffReqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire running = runFwdOut_ff | runRevOut_ff;
    property p_shut;
        outputShutoffIn |-> shutoffReqOut;
    endproperty
    a_shut: assert property (p_shut) else $error("shutoff not passed on");
    property p_excl;
        !(runFwdOut_ff && runRevOut_ff);
    endproperty
    a_excl: assert property (p_excl) else $error("both directions");
    property p_reset;
        @(posedge clk) disable iff (1'b0) rst |=> !running && !decelReqOut_ff;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left a request");
    property p_decel_norun;
        decelReqOut_ff |-> !running;
    endproperty
    a_decel_norun: assert property (p_decel_norun) else $error("decel while run");
    property p_fwd_cause;
        $rose(runFwdOut_ff) |-> $past(fwdStartIn) || $past(fwdStartIn, 2) || $past(fwdStartIn, 3);
    endproperty
    a_fwd_cause: assert property (p_fwd_cause) else $error("fwd without start");
    property p_hold_drop;
        (!stopHoldIn && !jogIn && termIn == 10'h000 && !fwdStartIn && !revStartIn) [*2]
            |=> !running;
    endproperty
    a_hold_drop: assert property (p_hold_drop) else $error("run survived release");
    property p_coast_quiet;
        shutoffReqOut && !outputShutoffIn |-> !running && !decelReqOut_ff;
    endproperty
    a_coast_quiet: assert property (p_coast_quiet) else $error("coast not quiet");
    property p_coast_from_wait;
        $rose(shutoffReqOut) && !outputShutoffIn |-> $past(decelReqOut_ff);
    endproperty
    a_coast_from_wait: assert property (p_coast_from_wait) else $error("coast early");
    property p_decel_end;
        $fell(decelReqOut_ff) |-> $past(rampDoneIn) || running || shutoffReqOut;
    endproperty
    a_decel_end: assert property (p_decel_end) else $error("decel cut short");
endmodule
bind start_stop_command_logic start_stop_checker u_chk (.clk, .rst, .fwdStartIn, .revStartIn,
    .termIn, .stopHoldIn, .jogIn, .outputShutoffIn, .rampDoneIn, .runFwdOut_ff, .runRevOut_ff,
    .decelReqOut_ff, .shutoffReqOut);

// ### bench/start_stop_command_logic_bench.sv
`timescale 1ns/100ps
`include "start_stop_regs.vh"
module start_stop_command_logic_bench;
    localparam TICK = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wrData = 16'h0000;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic wantFwd = 1'b0;
    logic wantRev = 1'b0;
    logic wantHold = 1'b0;
    logic rampSlow = 1'b0;
    logic [9:0] termIn = 10'h000;
    logic jogIn = 1'b0;
    logic jogEnableIn = 1'b0;
    logic outputShutoffIn = 1'b0;
    logic [4:0] flags = 5'h00;
    logic [15:0] v;
    wire [15:0] rdData;
    wire fwdStartIn, revStartIn, stopHoldIn, rampDoneIn;
    wire runFwdOut_ff, runRevOut_ff, decelReqOut_ff, shutoffReqOut;
    wire [4:0] openCollOut_ff;
    wire [1:0] relayOut_ff;
    integer seed = 71;
    integer fails = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer i, n, sec;
    start_stop_command_logic #(.TICK_CYCLES(TICK), .WIDTH(16)) DUT (.clk(clk), .rst(rst),
        .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .fwdStartIn(fwdStartIn), .revStartIn(revStartIn), .termIn(termIn),
        .stopHoldIn(stopHoldIn), .jogIn(jogIn), .jogEnableIn(jogEnableIn),
        .outputShutoffIn(outputShutoffIn), .rampDoneIn(rampDoneIn),
        .freqReachedFlag(flags[0]), .powerFailFlag(flags[1]), .overloadFlag(flags[2]),
        .freqDetectFlag(flags[3]), .faultFlag(flags[4]), .runFwdOut_ff(runFwdOut_ff),
        .runRevOut_ff(runRevOut_ff), .decelReqOut_ff(decelReqOut_ff),
        .shutoffReqOut(shutoffReqOut), .openCollOut_ff(openCollOut_ff),
        .relayOut_ff(relayOut_ff));
    contact_panel panel (.clk(clk), .wantFwd(wantFwd), .wantRev(wantRev), .wantHold(wantHold),
        .rampSlow(rampSlow), .runOut(runFwdOut_ff | runRevOut_ff), .decelReq(decelReqOut_ff),
        .fwdStartIn(fwdStartIn), .revStartIn(revStartIn), .stopHoldIn(stopHoldIn),
        .rampDoneIn(rampDoneIn));
    initial begin
        forever #20 clk = ~clk;
    end
    // Running flag on openCollOut_ff[0] is left out here and checked on its own: it stays low while coasting
    function automatic logic [5:0] outExp(input logic [4:0] f, input logic inv);
        outExp = {1'b0, f[4], f[3:1], f[0] ^ inv};
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop;
        end
    end
    task cyc(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task chk(input bit ok, input string m);
        tests_run = tests_run + 1;
        if (!ok) begin
            fails = fails + 1;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Idle cycle after each strobe so back-to-back calls never reassign it in one step
    task wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        cyc(1);
        wrEn <= 1'b0;
        cyc(1);
    endtask
    task rd(input logic [7:0] a, output logic [15:0] d);
        addr <= a;
        rdEn <= 1'b1;
        cyc(1);
        d = rdData;
        rdEn <= 1'b0;
        cyc(1);
    endtask
    task waitStop;
        n = 0;
        while (decelReqOut_ff === 1'b1 && n < 60) begin
            cyc(1);
            n = n + 1;
        end
        rd(`SS_ADDR_STATUS, v);
        chk(v[2:0] === 3'h0, "not stopped");
    endtask
    initial begin
        cyc(16);
        rst <= 1'b0;
        for (i = 0; i < 7; i = i + 1) begin
            rd(`SS_ADDR_OUT_FIRST + i[7:0], v);
            v = (i < 5) ? i[15:0] : ((i == 5) ? `SS_FN_FAULT : `SS_FN_NONE);
            chk(rdData === v, "out default");
        end
        rd(`SS_ADDR_STOP_SEL, v);
        chk(v === `SS_STOP_SEL_RESET, "stop default");
        rd(`SS_ADDR_STATUS, v);
        chk(v[2:0] === 3'h0, "reset state");
        wr(`SS_ADDR_IN_FIRST, 16'h0000);
        wantFwd <= 1'b1;
        cyc(2);
        chk(runFwdOut_ff === 1'b0, "fwd unassigned");
        wantFwd <= 1'b0;
        wr(`SS_ADDR_IN_FIRST, `SS_FN_FWD_START);
        wr(`SS_ADDR_IN_FIRST + 8'h01, `SS_FN_REV_START);
        wantFwd <= 1'b1;
        cyc(1);
        chk(runFwdOut_ff === 1'b1, "fwd run");
        wantRev <= 1'b1;
        cyc(1);
        chk(decelReqOut_ff === 1'b1, "both on");
        wantFwd <= 1'b0;
        cyc(1);
        chk(runRevOut_ff === 1'b1, "rev run");
        wantRev <= 1'b0;
        cyc(1);
        chk(decelReqOut_ff === 1'b1, "both off");
        chk(openCollOut_ff[0] === 1'b1, "run flag");
        waitStop;
        $display("two-wire done");
        wr(`SS_ADDR_STOP_SEL, `SS_STOP_DECEL_DIR);
        wantRev <= 1'b1;
        cyc(1);
        chk((runFwdOut_ff | runRevOut_ff) === 1'b0, "rev alone");
        wantFwd <= 1'b1;
        cyc(1);
        chk(runRevOut_ff === 1'b1, "fwd rev");
        wantRev <= 1'b0;
        cyc(1);
        chk(runFwdOut_ff === 1'b1, "fwd only");
        wantFwd <= 1'b0;
        cyc(1);
        chk(decelReqOut_ff === 1'b1, "stop decel");
        waitStop;
        $display("direction mode done");
        // Slow ramp; ST_WAIT ignores rampDoneIn, so only the timer or a new start ends the wait
        rampSlow <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            sec = (i == 0) ? 0 : ((i == 1) ? 100 : ($random(seed) & 3) + 1);
            wr(`SS_ADDR_STOP_SEL, (i == 3 ? `SS_COAST_OFS : 16'h0000) + sec[15:0]);
            wantFwd <= 1'b1;
            cyc(2);
            wantFwd <= 1'b0;
            cyc(2);
            wantFwd <= 1'b1;
            cyc(1);
            chk(runFwdOut_ff === 1'b1, "restart");
            wantFwd <= 1'b0;
            n = 0;
            while (shutoffReqOut !== 1'b1 && n < 500) begin
                cyc(1);
                n = n + 1;
            end
            chk(n >= sec * TICK && n <= sec * TICK + 3, "coast delay");
        end
        rampSlow <= 1'b0;
        wr(`SS_ADDR_STOP_SEL, `SS_STOP_SEL_RESET);
        $display("coast done");
        wr(`SS_ADDR_USER_GROUP, 16'h0001);
        wr(`SS_ADDR_STOP_SEL, 16'h0005);
        wr(`SS_ADDR_OUT_FIRST + 8'h05, 16'h0000);
        rd(`SS_ADDR_STOP_SEL, v);
        chk(v === `SS_STOP_SEL_RESET, "locked stop");
        rd(`SS_ADDR_OUT_FIRST + 8'h05, v);
        chk(v === `SS_FN_FAULT, "locked relay");
        wr(`SS_ADDR_USER_GROUP, 16'h0000);
        wr(`SS_ADDR_OUT_FIRST + 8'h01, `SS_FN_INV_FIRST + 16'h0001);
        rd(`SS_ADDR_OUT_FIRST + 8'h01, v);
        chk(v === 16'h0065, "unlocked write");
        rd(8'h01, v);
        chk(v === 16'h0000, "unmapped");
        for (i = 0; i < 8; i = i + 1) begin
            flags <= 5'($random(seed));
            cyc(2);
            chk({relayOut_ff, openCollOut_ff[4:1]} === outExp(flags, 1'b1),
                "outputs");
            chk(openCollOut_ff[0] === 1'b0, "coast flag");
        end
        $display("settings done");
        wantHold <= 1'b1;
        wantFwd <= 1'b1;
        cyc(3);
        chk(runFwdOut_ff === 1'b0, "trigger only");
        wantFwd <= 1'b0;
        cyc(2);
        chk(runFwdOut_ff === 1'b1, "latched fwd");
        outputShutoffIn <= 1'b1;
        cyc(1);
        chk(shutoffReqOut === 1'b1, "shutoff");
        rd(`SS_ADDR_STATUS, v);
        chk(v[`SS_STAT_LATCH_RUN] === 1'b1, "latch kept");
        outputShutoffIn <= 1'b0;
        wantRev <= 1'b1;
        cyc(2);
        wantRev <= 1'b0;
        cyc(2);
        chk(runRevOut_ff === 1'b1, "latched rev");
        jogIn <= 1'b1;
        jogEnableIn <= 1'b1;
        wantHold <= 1'b0;
        cyc(2);
        rd(`SS_ADDR_STATUS, v);
        chk(v[`SS_STAT_LATCH_RUN] === 1'b1, "jog keeps");
        jogIn <= 1'b0;
        cyc(2);
        chk(runRevOut_ff === 1'b0, "hold off");
        rd(`SS_ADDR_STATUS, v);
        chk(v[`SS_STAT_LATCH_RUN] === 1'b0, "latch cleared");
        waitStop;
        wr(`SS_ADDR_IN_FIRST + 8'h02, `SS_FN_STOP_HOLD);
        termIn <= 10'h001;
        cyc(2);
        rd(`SS_ADDR_STATUS, v);
        chk(v[6:5] === 2'b11, "terminal hold");
        termIn <= 10'h000;
        $display("three-wire done");
        wantFwd <= 1'b1;
        cyc(3);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        chk(runFwdOut_ff === 1'b0, "reset run");
        wantFwd <= 1'b0;
        rd(`SS_ADDR_OUT_FIRST + 8'h01, v);
        chk(v === 16'h0001, "reset sel");
        $display("reset done");
        report_and_stop;
    end
endmodule
